// file: verilog/sadc_seq.sv
// Top of the 10-bit successive-approximation sequencer with register file
// Assumes an external comparator and ladder DAC driven from ladderCode
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Writing zero to done flag starts conversion
// - Result register cleared at conversion start
// - MSB set as trial, code sent out
// - Keep bit if ladder below input, else clear
// - Repeat step down to least significant bit
// - Decided bits held; ten bits at end
// - Conversion ends 61 internal clocks after start
// - Interrupt request set on completion cycle
// - High-speed internal clock is half oscillator
module sadc_seq
	import sadc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// AXI4-Lite write
	input  wire sadc_addr_t  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire sadc_addr_t  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Comparator and ladder
	output sadc_code_t       ladderCode,
	input  wire logic        ladderBelowInput,
	// System
	output logic             convBusy,
	output logic             irqOut
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	sadc_state_e             state_ff;
	sadc_state_e             nxt_state;
	sadc_code_t              sar_ff;
	sadc_code_t              nxt_sar;
	logic [5:0]              cycCnt_ff;
	logic [2:0]              phase_ff;
	logic [3:0]              bitIdx_ff;
	logic                    doneFlag_ff;
	logic                    hsMode_ff;
	logic [`SADC_IRQ_W-1:0]  irqStat_ff;
	logic [`SADC_IRQ_W-1:0]  irqEn_ff;
	logic [`SADC_IRQ_W-1:0]  nxt_irqStat;
	logic                    wrEn;
	sadc_addr_t              wrAddr;
	logic [31:0]             wrData;
	logic [3:0]              wrStrb;
	logic                    phiTick;
	logic                    wrOk;
	logic                    rdOk;
	logic [31:0]             rdData;

	////////////////////////////////////////////////////////////////////////////
	// Bus front end and internal clock enable
	sadc_axil_slave sadc_axil_slave_inst (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrEn          (wrEn),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrOk          (wrOk),
		.rdData        (rdData),
		.rdOk          (rdOk)
	);

	sadc_tick_gen sadc_tick_gen_inst (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.highSpeedMode (hsMode_ff),
		.phiTick       (phiTick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	wire        wrLow   = wrEn && wrStrb[0];
	wire        wrCtrl  = wrLow && (wrAddr == `SADC_OFF_CTRL);
	wire        wrIrqEn = wrLow && (wrAddr == `SADC_OFF_IRQ_EN);
	wire        wrClr   = wrLow && (wrAddr == `SADC_OFF_IRQ_CLR);
	// Writing one to the flag is ignored; only zero starts
	wire        startReq = wrCtrl && !wrData[`SADC_CTRL_DONE_BIT];
	assign wrOk = (wrAddr == `SADC_OFF_CTRL) ||
		(wrAddr == `SADC_OFF_RESULT) || (wrAddr == `SADC_OFF_IRQ_STAT) ||
		(wrAddr == `SADC_OFF_IRQ_CLR) || (wrAddr == `SADC_OFF_IRQ_EN);
	wire        rdCtrl = (s_axi_araddr == `SADC_OFF_CTRL);
	wire        rdRes  = (s_axi_araddr == `SADC_OFF_RESULT);
	wire        rdStat = (s_axi_araddr == `SADC_OFF_IRQ_STAT);
	wire        rdClr  = (s_axi_araddr == `SADC_OFF_IRQ_CLR);
	wire        rdEn   = (s_axi_araddr == `SADC_OFF_IRQ_EN);
	assign rdOk = rdCtrl || rdRes || rdStat || rdClr || rdEn;
	wire [31:0] ctrlWord = {29'h0, hsMode_ff, convBusy, doneFlag_ff};
	// Clear register is write-only and reads back zero
	assign rdData =
		rdCtrl ? ctrlWord :
		rdRes  ? {22'h0, sar_ff} :
		rdStat ? {30'h0, irqStat_ff} :
		rdEn   ? {30'h0, irqEn_ff} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Successive approximation datapath
	wire        convTick    = phiTick && (state_ff == ST_CONV);
	wire        trialStep   = convTick && (phase_ff == 3'h0);
	wire        decideStep  = convTick && (phase_ff == `SADC_STEP_LAST);
	wire        lastDecide  = decideStep && (bitIdx_ff == 4'h0);
	wire        completeEvt = phiTick && (state_ff == ST_FINAL) && !startReq;
	wire [5:0]  cycCntInc   = cycCnt_ff + 6'h01;
	sadc_code_t bitMask;

	assign bitMask    = sadc_code_t'(1) << bitIdx_ff;
	assign ladderCode = sar_ff;
	// Guard for the stop instruction lives outside
	assign convBusy   = (state_ff != ST_IDLE);
	assign irqOut     = |(irqStat_ff & irqEn_ff);

	always_comb begin
		nxt_sar = sar_ff;
		if (startReq)
			nxt_sar = '0;
		else if (trialStep)
			nxt_sar = sar_ff | bitMask;
		else if (decideStep && !ladderBelowInput)
			nxt_sar = sar_ff & ~bitMask;
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (startReq)
					nxt_state = ST_CONV;
			end
			ST_CONV: begin
				if (startReq)
					nxt_state = ST_CONV;
				else if (lastDecide)
					nxt_state = ST_FINAL;
			end
			ST_FINAL: begin
				if (startReq)
					nxt_state = ST_CONV;
				else if (completeEvt)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Set wins over a clear in the same cycle
	always_comb begin
		nxt_irqStat = irqStat_ff & ~(wrClr ? wrData[`SADC_IRQ_W-1:0] : 2'h0);
		nxt_irqStat[`SADC_IRQ_DONE_BIT] =
			nxt_irqStat[`SADC_IRQ_DONE_BIT] | completeEvt;
		nxt_irqStat[`SADC_IRQ_OVR_BIT] =
			nxt_irqStat[`SADC_IRQ_OVR_BIT] | (startReq && convBusy);
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			sar_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			sar_ff   <= nxt_sar;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycCnt_ff <= 6'h00;
			phase_ff  <= 3'h0;
			bitIdx_ff <= `SADC_MSB_IDX;
		end else if (startReq) begin
			cycCnt_ff <= 6'h00;
			phase_ff  <= 3'h0;
			bitIdx_ff <= `SADC_MSB_IDX;
		end else if (phiTick && convBusy) begin
			cycCnt_ff <= cycCntInc;
			phase_ff  <= decideStep ? 3'h0 : phase_ff + 3'h1;
			if (decideStep && !lastDecide)
				bitIdx_ff <= bitIdx_ff - 4'h1;
		end
	end

	// A start in the completion cycle wins; the flag stays clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			doneFlag_ff <= `SADC_RST_DONE;
		else if (startReq)
			doneFlag_ff <= 1'b0;
		else if (completeEvt)
			doneFlag_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hsMode_ff  <= `SADC_RST_HS;
			irqEn_ff   <= `SADC_RST_IRQ_EN;
			irqStat_ff <= '0;
		end else begin
			if (wrCtrl)
				hsMode_ff <= wrData[`SADC_CTRL_HS_BIT];
			if (wrIrqEn)
				irqEn_ff <= wrData[`SADC_IRQ_W-1:0];
			irqStat_ff <= nxt_irqStat;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic       cmpSeen_ff;
	sadc_code_t maskSeen_ff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmpSeen_ff  <= 1'b0;
			maskSeen_ff <= '0;
		end else begin
			cmpSeen_ff  <= ladderBelowInput;
			maskSeen_ff <= bitMask;
		end
	end

	sequence s_start;
		startReq;
	endsequence
	sequence s_msbTrial;
		trialStep && !startReq && (bitIdx_ff == `SADC_MSB_IDX);
	endsequence
	sequence s_decide;
		decideStep && !startReq;
	endsequence
	// Mode must hold two cycles; a switch changes the divider limit
	sequence s_hsTick;
		phiTick && hsMode_ff ##1 hsMode_ff [*2];
	endsequence

	a_start_clears_result: assert property (
		s_start |=> (sar_ff == '0) && (state_ff == ST_CONV))
		else $error("Result not cleared at start");
	a_msb_trial_set: assert property (
		s_msbTrial |=> sar_ff[9] && (ladderCode[8:0] == 9'h000))
		else $error("MSB trial bit not set");
	a_bit_decided: assert property (
		s_decide |=> ((sar_ff & maskSeen_ff) != '0) == cmpSeen_ff)
		else $error("Trial bit decision wrong");
	a_upper_bits_held: assert property (
		(convBusy && !startReq) |=>
			((sar_ff ^ $past(sar_ff)) & ~maskSeen_ff) == '0)
		else $error("Decided bit changed");
	a_complete_at_61: assert property (
		completeEvt |-> (cycCntInc == `SADC_CONV_TICKS))
		else $error("Completion not at 61 internal clocks");
	a_irq_on_done: assert property (
		completeEvt |=> irqStat_ff[`SADC_IRQ_DONE_BIT] && doneFlag_ff)
		else $error("Interrupt request or flag not set");
	a_restart_counter: assert property (
		s_start |=> (cycCnt_ff == 6'h00) && (bitIdx_ff == `SADC_MSB_IDX)
			&& !doneFlag_ff)
		else $error("Restart did not reset sequence");
	a_half_rate_tick: assert property (
		s_hsTick |-> phiTick && !$past(phiTick))
		else $error("High-speed tick not half rate");
	a_ten_decisions: assert property (
		lastDecide && !startReq |=> (state_ff == ST_FINAL) ##0
			(cycCnt_ff == 6'h3C))
		else $error("LSB decision at wrong step");
endmodule
`default_nettype wire

// file: verilog/sadc_cfg.svh
// Offsets, field positions, reset values and step counts of the SAR sequencer
// Assumes inclusion by bare name from package and modules
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_ADDR_W       8
`define SADC_OFF_CTRL     8'h00
`define SADC_OFF_RESULT   8'h04
`define SADC_OFF_IRQ_STAT 8'h08
`define SADC_OFF_IRQ_CLR  8'h0C
`define SADC_OFF_IRQ_EN   8'h10

`define SADC_CTRL_DONE_BIT 0
`define SADC_CTRL_BUSY_BIT 1
`define SADC_CTRL_HS_BIT   2
`define SADC_IRQ_DONE_BIT  0
`define SADC_IRQ_OVR_BIT   1
`define SADC_IRQ_W         2

`define SADC_RST_DONE   1'b1
`define SADC_RST_HS     1'b1
`define SADC_RST_IRQ_EN 2'h0

`define SADC_RES_W      10
`define SADC_MSB_IDX    4'h9
`define SADC_STEP_LAST  3'h5
`define SADC_CONV_TICKS 6'h3D
`define SADC_DIV_HS_LAST 3'h1
`define SADC_DIV_MS_LAST 3'h7

`define SADC_RESP_OKAY   2'h0
`define SADC_RESP_DECERR 2'h3

`endif

// file: verilog/sadc_pkg.sv
// Types shared by the SAR sequencer modules
// Assumes sadc_cfg.svh is on the include path
`include "sadc_cfg.svh"

package sadc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_CONV  = 3'h2,
		ST_FINAL = 3'h4
	} sadc_state_e;

	typedef logic [`SADC_RES_W-1:0]  sadc_code_t;
	typedef logic [`SADC_ADDR_W-1:0] sadc_addr_t;
endpackage

// file: verilog/sadc_tick_gen.sv
// Internal clock enable generator for the SAR sequencer
// Assumes sys_clk is the main oscillator input
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_tick_gen
	import sadc_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Mode and enable
	input  wire logic highSpeedMode,
	output logic      phiTick
);
	logic [2:0] divCnt_ff;
	wire  [2:0] divLast;

	// Middle speed divides by eight
	assign divLast = highSpeedMode ? `SADC_DIV_HS_LAST : `SADC_DIV_MS_LAST;
	assign phiTick = (divCnt_ff >= divLast);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			divCnt_ff <= 3'h0;
		else
			divCnt_ff <= phiTick ? 3'h0 : divCnt_ff + 3'h1;
	end
endmodule
`default_nettype wire

// file: verilog/sadc_axil_slave.sv
// AXI4-Lite slave front end: one write and one read outstanding
// Assumes the register file answers decode combinationally
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_axil_slave
	import sadc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Write channels
	input  wire sadc_addr_t  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read channels
	input  wire sadc_addr_t  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Register file side
	output logic             wrEn,
	output sadc_addr_t       wrAddr,
	output logic [31:0]      wrData,
	output logic [3:0]       wrStrb,
	input  wire logic        wrOk,
	input  wire logic [31:0] rdData,
	input  wire logic        rdOk
);
	logic awHeld_ff;
	logic wHeld_ff;
	wire  awTake;
	wire  wTake;
	wire  arTake;

	assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign awTake = s_axi_awvalid && s_axi_awready;
	assign wTake  = s_axi_wvalid && s_axi_wready;
	assign arTake = s_axi_arvalid && s_axi_arready;
	// Commit once both halves are held, whatever their order
	assign wrEn   = awHeld_ff && wHeld_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_ff    <= 1'b0;
			wHeld_ff     <= 1'b0;
			wrAddr       <= '0;
			wrData       <= 32'h0000_0000;
			wrStrb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SADC_RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld_ff <= 1'b1;
				wrAddr    <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_ff <= 1'b1;
				wrData   <= s_axi_wdata;
				wrStrb   <= s_axi_wstrb;
			end
			if (wrEn) begin
				awHeld_ff    <= 1'b0;
				wHeld_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOk ? `SADC_RESP_OKAY : `SADC_RESP_DECERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SADC_RESP_OKAY;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdData;
			s_axi_rresp  <= rdOk ? `SADC_RESP_OKAY : `SADC_RESP_DECERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// file: sim/sadc_ladder_model.sv
// Behavioural comparator and resistor ladder facing the SAR sequencer
// Assumes the bench drives the analog input as a code in 1/1024 steps
`timescale 1ns/100ps
`default_nettype none

module sadc_ladder_model
	import sadc_pkg::*;
(
	// Ladder code from the sequencer
	input  wire sadc_code_t  ladderCode,
	// Analog input, 0 to 1024 steps of the reference
	input  wire logic [10:0] analogInputVoltage,
	// Comparator result
	output logic             ladderBelowInput
);
	// Ladder gives code/1024 of full scale, code 0 gives zero volts
	assign ladderBelowInput = {1'b0, ladderCode} < analogInputVoltage;
endmodule
`default_nettype wire

// file: sim/test_sadc_seq.sv
// Self-checking bench of the SAR sequencer over AXI4-Lite
// Assumes the ladder model on the comparator side and a 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end

module test_sadc_seq;
	import sadc_pkg::*;
	logic        sys_clk = 0, rst_n = 0;
	sadc_addr_t  awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	sadc_code_t  ladderCode;
	logic        ladderBelowInput, convBusy, irqOut, prevBusy = 0;
	logic [10:0] inputLevel = '0;
	logic [10:0] lvl;
	logic [33:0] expQ[$];
	logic [33:0] top;
	int          fails = 0, nTests = 0, cycles = 0, cyc;
	int          levelSet[5] = '{0, 1, 512, 1023, 1024};

	sadc_seq sadc_seq_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ladderCode(ladderCode), .ladderBelowInput(ladderBelowInput),
		.convBusy(convBusy), .irqOut(irqOut));
	sadc_ladder_model sadc_ladder_model_inst (.ladderCode(ladderCode),
		.analogInputVoltage(inputLevel),
		.ladderBelowInput(ladderBelowInput));

	// Clock stays at 10 MHz throughout, above the comparator minimum
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (fails == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic axiWrite(input sadc_addr_t a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (awvalid && awready) begin
				aw = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				w = 1;
				wvalid <= 0;
			end
		end
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		`CHK(bresp, er)
		bready <= 0;
		@(posedge sys_clk);
	endtask

	task automatic axiRead(input sadc_addr_t a, input logic [1:0] er,
		input logic [31:0] ed);
		expQ.push_back({er, ed});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge sys_clk);
		rready <= 0;
		@(posedge sys_clk);
	endtask

	// Start with done written 0, then time the run until busy falls
	task automatic convRun(input logic [10:0] v, input logic hs);
		inputLevel <= v;
		axiWrite(`SADC_OFF_CTRL, {29'h0, hs, 2'b00}, `SADC_RESP_OKAY);
		cyc = 0;
		while (convBusy === 1'b1 && cyc < 1000) begin
			@(posedge sys_clk);
			cyc++;
		end
	endtask

	// Result and status after a finished run, then clear
	task automatic convCheck(input logic [10:0] v, input logic hs,
		input logic [1:0] st);
		axiRead(`SADC_OFF_RESULT, `SADC_RESP_OKAY,
			(v == 0) ? 32'h0 : 32'(v - 1));
		axiRead(`SADC_OFF_CTRL, `SADC_RESP_OKAY, {29'h0, hs, 2'b01});
		axiRead(`SADC_OFF_IRQ_STAT, `SADC_RESP_OKAY, {30'h0, st});
		axiWrite(`SADC_OFF_IRQ_CLR, 32'h0000_0003, `SADC_RESP_OKAY);
		axiRead(`SADC_OFF_IRQ_STAT, `SADC_RESP_OKAY, 32'h0000_0000);
		`CHK(irqOut, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (expQ.size() == 0)
				`CHK(1'b1, 1'b0)
			else begin
				top = expQ.pop_front();
				`CHK({rresp, rdata}, top)
			end
		end
	end

	// Register must read zero just after a fresh start
	always @(posedge sys_clk) begin
		prevBusy <= convBusy;
		if (convBusy === 1'b1 && prevBusy === 1'b0)
			`CHK(ladderCode, 10'h000)
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// No stop request exists here; the clock never halts mid-run
	initial begin
		void'($urandom(28023));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		@(posedge sys_clk);
		axiRead(`SADC_OFF_CTRL, `SADC_RESP_OKAY, 32'h0000_0005);
		axiRead(`SADC_OFF_RESULT, `SADC_RESP_OKAY, 32'h0000_0000);
		axiRead(`SADC_OFF_IRQ_STAT, `SADC_RESP_OKAY, 32'h0000_0000);
		axiRead(`SADC_OFF_IRQ_EN, `SADC_RESP_OKAY, 32'h0000_0000);
		axiRead(8'h20, `SADC_RESP_DECERR, 32'h0000_0000);
		axiWrite(8'h20, 32'h0000_0000, `SADC_RESP_DECERR);
		// Writing done as 1 must not start anything
		axiWrite(`SADC_OFF_CTRL, 32'h0000_0005, `SADC_RESP_OKAY);
		`CHK(convBusy, 1'b0)
		axiWrite(`SADC_OFF_IRQ_EN, 32'h0000_0003, `SADC_RESP_OKAY);
		for (int i = 0; i < 9; i++) begin
			lvl = (i < 5) ? 11'(levelSet[i]) : 11'($urandom % 1025);
			convRun(lvl, 1'b1);
			`CHK(cyc inside {[116:124]}, 1'b1)
			`CHK(irqOut, 1'b1)
			convCheck(lvl, 1'b1, 2'b01);
		end
		// Restart in mid-run: timing runs again from the second start
		inputLevel <= 11'd700;
		axiWrite(`SADC_OFF_CTRL, 32'h0000_0004, `SADC_RESP_OKAY);
		inputLevel <= 11'd300;
		repeat (40) @(posedge sys_clk);
		`CHK(convBusy, 1'b1)
		convRun(11'd300, 1'b1);
		`CHK(cyc inside {[116:124]}, 1'b1)
		convCheck(11'd300, 1'b1, 2'b11);
		// Masked completion keeps the output low until enabled
		axiWrite(`SADC_OFF_IRQ_EN, 32'h0000_0000, `SADC_RESP_OKAY);
		convRun(11'd77, 1'b1);
		`CHK(irqOut, 1'b0)
		axiWrite(`SADC_OFF_IRQ_EN, 32'h0000_0001, `SADC_RESP_OKAY);
		`CHK(irqOut, 1'b1)
		convCheck(11'd77, 1'b1, 2'b01);
		// Middle speed: eight clocks per internal tick
		convRun(11'd1000, 1'b0);
		`CHK(cyc inside {[482:490]}, 1'b1)
		convCheck(11'd1000, 1'b0, 2'b01);
		stop_test();
	end
endmodule
`default_nettype wire
